// ---- design/vfs_frame_gen.sv ----
// Frame-level video timing generator with register port and sync pins
//
// Functional notes
// - Vertical counts are in half lines; non-interlaced visible count is twice lines.
// - Equalisation, sync and blank periods count half lines; blanking is their sum.
// - Sync low lasts broad pulse in vertical sync, half sync in equalisation.
// - Flyback loops are half a line; equalisation uses short display.
// - Vertical sync half lines hold only broad pulse then front porch.
// - Bootstrap word after reset sets PLL, clock source, alignment; then clear enable.
// - In master mode, enabling starts generation immediately at the start of frame sync.
// - Sync and blank feed DACs unless control bits 6 or 11 suppress them.
// - Sync and blank take an extra programmable delay of zero to seven clocks.
// - Master mode drives both pins low active; frame pin carries plain frame sync.
// - Bits 5:4 select serrated composite, plain composite or line sync.
// - Slave mode takes both pins as inputs and starts frames from the frame pin.
// - Line timing counts are in screen units of four pixels.
// - Flyback flag rises entering frame flyback, falls entering active display.
`timescale 1ns/1ns
`default_nettype none
module vfs_frame_gen
  import vfs_pkg::*;
#(
  parameter int CW = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Bootstrap results
  output logic [4:0] pll_factor,
  output logic clk_src_sel,
  output logic port_align64,
  // Sync pins, three-signal form
  input wire logic frame_sync_pin_n_i,
  output logic frame_sync_pin_n_o,
  output logic frame_sync_pin_n_oe,
  input wire logic combined_sync_pin_n_i,
  output logic combined_sync_pin_n_o,
  output logic combined_sync_pin_n_oe,
  // DAC feed and status
  output logic dac_sync_n,
  output logic dac_blank_n,
  output logic vertical_flyback_flag
);
  import vfs_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [11:0] ctrl_q;
  logic [6:0] boot_q;
  logic boot_done_q;
  logic [CW-1:0] halfsync_q, backporch_q, display_q, shortdisp_q, broad_q, linetime_q;
  logic [CW-1:0] vvis_q, leadeq_q, traileq_q, vsync_q, extra_vertical_blank_halflines_q, lead_q;
  logic [31:0] rdata_q;
  logic [7:0] boot_wait_q;

  wire en = ctrl_q[VFS_CTL_EN];
  wire slave = ctrl_q[VFS_CTL_SLAVE];
  wire [1:0] pinsel = ctrl_q[VFS_CTL_PINSEL_LO +: 2];
  wire [2:0] dly_sel = ctrl_q[VFS_CTL_DLY_LO +: 3];
  wire wr_ctrl = reg_wr && reg_addr == VFS_ADR_CTRL;
  // Boot word taken only once the settle time after reset has passed
  wire boot_ok = boot_wait_q == 8'(VFS_BOOT_WAIT_CYC);
  wire wr_boot = reg_wr && reg_addr == VFS_ADR_BOOT && boot_ok && !boot_done_q;
  // Timing registers ignore writes while running
  wire wr_par = reg_wr && !en;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      boot_wait_q <= 8'h00;
    end else if (!boot_ok) begin
      boot_wait_q <= boot_wait_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      boot_q <= VFS_BOOT_RESET;
      boot_done_q <= 1'b0;
    end else if (wr_boot) begin
      boot_q <= reg_wdata[6:0];
      boot_done_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= VFS_CTL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata[11:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      halfsync_q <= '0;
      backporch_q <= '0;
      display_q <= '0;
      shortdisp_q <= '0;
      broad_q <= '0;
      linetime_q <= '0;
      vvis_q <= '0;
      leadeq_q <= '0;
      traileq_q <= '0;
      vsync_q <= '0;
      extra_vertical_blank_halflines_q <= '0;
      lead_q <= '0;
    end else if (wr_par) begin
      case (reg_addr)
        VFS_ADR_HALFSYNC: halfsync_q <= reg_wdata[CW-1:0];
        VFS_ADR_BACKPORCH: backporch_q <= reg_wdata[CW-1:0];
        VFS_ADR_DISPLAY: display_q <= reg_wdata[CW-1:0];
        VFS_ADR_SHORTDISP: shortdisp_q <= reg_wdata[CW-1:0];
        VFS_ADR_BROADPULSE: broad_q <= reg_wdata[CW-1:0];
        VFS_ADR_LINETIME: linetime_q <= reg_wdata[CW-1:0];
        VFS_ADR_VVISIBLE: vvis_q <= reg_wdata[CW-1:0];
        VFS_ADR_LEADEQ: leadeq_q <= reg_wdata[CW-1:0];
        VFS_ADR_TRAILEQ: traileq_q <= reg_wdata[CW-1:0];
        VFS_ADR_VSYNC: vsync_q <= reg_wdata[CW-1:0];
        VFS_ADR_EXTRA_VERTICAL_BLANK_HALFLINES: extra_vertical_blank_halflines_q <= reg_wdata[CW-1:0];
        VFS_ADR_LEAD: lead_q <= reg_wdata[CW-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Slave pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] vs_sync_q, cs_sync_q;
  logic vs_prev_q;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vs_sync_q <= 2'b11;
      cs_sync_q <= 2'b11;
      vs_prev_q <= 1'b1;
    end else begin
      vs_sync_q <= {vs_sync_q[0], frame_sync_pin_n_i};
      cs_sync_q <= {cs_sync_q[0], combined_sync_pin_n_i};
      vs_prev_q <= vs_sync_q[1];
    end
  end
  wire ext_frame = slave && vs_prev_q && !vs_sync_q[1];

  // ----------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------
  vfs_phase_t ph_q, ph_d;
  vfs_seg_t sg_q, sg_d;
  logic [CW-1:0] seg_cnt_q, seg_cnt_d, line_cnt_q, line_cnt_d, hl_cnt_q, hl_cnt_d;
  logic en_q;

  wire [CW-1:0] half_line = linetime_q >> 1;
  wire flyback = ph_q != VFS_PH_VISIBLE && ph_q != VFS_PH_EXTRA_VERTICAL_BLANK_HALFLINES;
  // Flyback half lines end at half line time, others at full line time
  wire [CW-1:0] line_end = flyback ? half_line : linetime_q;
  wire line_done = line_cnt_q == line_end - 1'b1;
  wire start = (en && !en_q && !slave) || (en && ext_frame);

  // Plain mux: a function reading registers would hide them from the sensitivity
  wire [CW-1:0] ph_len = (ph_q == VFS_PH_PREEQ) ? leadeq_q :
    (ph_q == VFS_PH_VSYNC) ? vsync_q :
    (ph_q == VFS_PH_POSTEQ) ? traileq_q :
    (ph_q == VFS_PH_EXTRA_VERTICAL_BLANK_HALFLINES) ? extra_vertical_blank_halflines_q :
    (ph_q == VFS_PH_VISIBLE) ? vvis_q : '0;

  function automatic vfs_phase_t next_ph(input vfs_phase_t p);
    case (p)
      VFS_PH_PREEQ: next_ph = VFS_PH_VSYNC;
      VFS_PH_VSYNC: next_ph = VFS_PH_POSTEQ;
      VFS_PH_POSTEQ: next_ph = VFS_PH_EXTRA_VERTICAL_BLANK_HALFLINES;
      VFS_PH_EXTRA_VERTICAL_BLANK_HALFLINES: next_ph = VFS_PH_VISIBLE;
      default: next_ph = VFS_PH_PREEQ;
    endcase
  endfunction : next_ph

  // Full lines use two half-line units each
  wire [CW-1:0] hl_step = flyback ? CW'(1) : CW'(2);
  wire phase_done = hl_cnt_q + hl_step >= ph_len;

  // Segment length in screen units
  always_comb begin
    logic [CW-1:0] seg_len;
    seg_len = '0;
    case (sg_q)
      VFS_SG_SYNC1: seg_len = (ph_q == VFS_PH_VSYNC) ? broad_q : halfsync_q;
      VFS_SG_SYNC2: seg_len = halfsync_q;
      VFS_SG_BACK: seg_len = backporch_q;
      VFS_SG_DISP: seg_len = (flyback) ? shortdisp_q : display_q;
      default: seg_len = '1;
    endcase
    ph_d = ph_q;
    sg_d = sg_q;
    seg_cnt_d = seg_cnt_q + 1'b1;
    line_cnt_d = line_cnt_q + 1'b1;
    hl_cnt_d = hl_cnt_q;
    if (!en) begin
      ph_d = VFS_PH_IDLE;
    end else if (start) begin
      ph_d = VFS_PH_PREEQ;
      sg_d = VFS_SG_SYNC1;
      seg_cnt_d = '0;
      line_cnt_d = '0;
      hl_cnt_d = '0;
    end else if (ph_q != VFS_PH_IDLE) begin
      if (line_done) begin
        seg_cnt_d = '0;
        line_cnt_d = '0;
        sg_d = VFS_SG_SYNC1;
        if (phase_done) begin
          ph_d = next_ph(ph_q);
          hl_cnt_d = '0;
        end else begin
          hl_cnt_d = hl_cnt_q + hl_step;
        end
      end else if (sg_q != VFS_SG_FRONT && seg_cnt_q == seg_len - 1'b1) begin
        seg_cnt_d = '0;
        // Vertical sync: broad pulse then straight to front porch
        if (sg_q == VFS_SG_SYNC1 && ph_q == VFS_PH_VSYNC) begin
          sg_d = VFS_SG_FRONT;
        end else if (sg_q == VFS_SG_SYNC1 && flyback) begin
          sg_d = VFS_SG_BACK;
        end else begin
          case (sg_q)
            VFS_SG_SYNC1: sg_d = VFS_SG_SYNC2;
            VFS_SG_SYNC2: sg_d = VFS_SG_BACK;
            VFS_SG_BACK: sg_d = VFS_SG_DISP;
            default: sg_d = VFS_SG_FRONT;
          endcase
        end
      end
    end
  end

  // Counters tick once per screen unit of four pixels
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ph_q <= VFS_PH_IDLE;
      sg_q <= VFS_SG_SYNC1;
      seg_cnt_q <= '0;
      line_cnt_q <= '0;
      hl_cnt_q <= '0;
      en_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      sg_q <= sg_d;
      seg_cnt_q <= seg_cnt_d;
      line_cnt_q <= line_cnt_d;
      hl_cnt_q <= hl_cnt_d;
      en_q <= en;
    end
  end

  // ----------------------------------------------------------------
  // Sync and blank generation
  // ----------------------------------------------------------------
  wire active = ph_q != VFS_PH_IDLE;
  wire in_sync = active && (sg_q == VFS_SG_SYNC1 || sg_q == VFS_SG_SYNC2);
  wire serr_n = !in_sync;
  wire vsync_n = !(active && ph_q == VFS_PH_VSYNC);
  // Line sync only from full-line sync segments
  wire hsync_n = !(in_sync && !flyback);
  wire plain_cs_n = vsync_n && hsync_n;
  wire blank_n = active && ph_q == VFS_PH_VISIBLE && sg_q == VFS_SG_DISP;
  wire pin_cs_n = pinsel[1] ? hsync_n : (pinsel[0] ? plain_cs_n : serr_n);
  wire [1:0] dly_out;

  vfs_delay_line #(.WIDTH(2), .DEPTH(8)) u_dly (
    .sys_clk(sys_clk),
    .rst(rst),
    .dly_sel(dly_sel),
    .din({serr_n, blank_n}),
    .dout(dly_out)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dac_sync_n <= 1'b1;
      dac_blank_n <= 1'b0;
      frame_sync_pin_n_o <= 1'b1;
      combined_sync_pin_n_o <= 1'b1;
      frame_sync_pin_n_oe <= 1'b0;
      combined_sync_pin_n_oe <= 1'b0;
      vertical_flyback_flag <= 1'b0;
    end else begin
      dac_sync_n <= dly_out[1] | ctrl_q[VFS_CTL_NOSYNC];
      dac_blank_n <= dly_out[0] | ctrl_q[VFS_CTL_NOBLANK];
      frame_sync_pin_n_o <= vsync_n;
      combined_sync_pin_n_o <= pin_cs_n;
      frame_sync_pin_n_oe <= !slave;
      combined_sync_pin_n_oe <= !slave;
      if (ph_d == VFS_PH_VISIBLE) begin
        vertical_flyback_flag <= 1'b0;
      end else if (ph_d != VFS_PH_IDLE) begin
        vertical_flyback_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bootstrap outputs and read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pll_factor <= 5'h00;
      clk_src_sel <= 1'b0;
      port_align64 <= 1'b0;
    end else begin
      pll_factor <= boot_q[VFS_BOOT_PLL_LO +: 5];
      clk_src_sel <= boot_q[VFS_BOOT_SRC];
      port_align64 <= boot_q[VFS_BOOT_ALIGN];
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    case (reg_addr)
      VFS_ADR_CTRL: rd_mux = {20'h0, ctrl_q};
      VFS_ADR_BOOT: rd_mux = {25'h0, boot_q};
      VFS_ADR_STATUS: rd_mux = {24'h0, boot_done_q, vertical_flyback_flag,
                                cs_sync_q[1], sg_q, ph_q[1:0]};
      default: rd_mux = 32'h0;
    endcase
    if (!en) begin
      case (reg_addr)
        VFS_ADR_HALFSYNC: rd_mux = 32'(halfsync_q);
        VFS_ADR_BACKPORCH: rd_mux = 32'(backporch_q);
        VFS_ADR_DISPLAY: rd_mux = 32'(display_q);
        VFS_ADR_SHORTDISP: rd_mux = 32'(shortdisp_q);
        VFS_ADR_BROADPULSE: rd_mux = 32'(broad_q);
        VFS_ADR_LINETIME: rd_mux = 32'(linetime_q);
        VFS_ADR_VVISIBLE: rd_mux = 32'(vvis_q);
        VFS_ADR_LEADEQ: rd_mux = 32'(leadeq_q);
        VFS_ADR_TRAILEQ: rd_mux = 32'(traileq_q);
        VFS_ADR_VSYNC: rd_mux = 32'(vsync_q);
        VFS_ADR_EXTRA_VERTICAL_BLANK_HALFLINES: rd_mux = 32'(extra_vertical_blank_halflines_q);
        VFS_ADR_LEAD: rd_mux = 32'(lead_q);
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_start_preeq: assert property (@(posedge sys_clk) disable iff (rst)
    (en && !en_q && !slave) |=> ph_q == VFS_PH_PREEQ && sg_q == VFS_SG_SYNC1)
    else $error("enable did not start frame sync");
  chk_vsync_seq: assert property (@(posedge sys_clk) disable iff (rst)
    (ph_q == VFS_PH_VSYNC && $changed(sg_q) && sg_q != VFS_SG_SYNC1) |-> sg_q == VFS_SG_FRONT)
    else $error("vertical sync line left broad pulse wrongly");
  chk_flag_vis: assert property (@(posedge sys_clk) disable iff (rst)
    (ph_q == VFS_PH_VISIBLE) |-> !vertical_flyback_flag)
    else $error("flyback flag set in visible area");
  chk_flag_fly: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(ph_q == VFS_PH_PREEQ) |-> vertical_flyback_flag)
    else $error("flyback flag missing in flyback");
  chk_pin_dir: assert property (@(posedge sys_clk) disable iff (rst)
    slave ##1 slave |-> !frame_sync_pin_n_oe && !combined_sync_pin_n_oe)
    else $error("pins driven in slave mode");
  chk_vs_plain: assert property (@(posedge sys_clk) disable iff (rst)
    !slave ##1 (ph_q != VFS_PH_VSYNC) |=> frame_sync_pin_n_o)
    else $error("frame sync pin low outside vertical sync");
  chk_nosync_dac: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl_q[VFS_CTL_NOSYNC] |=> dac_sync_n)
    else $error("sync reached DAC while suppressed");
  chk_blank_fly: assert property (@(posedge sys_clk) disable iff (rst)
    (flyback && dly_sel == 3'h0 && !ctrl_q[VFS_CTL_NOBLANK]) |=> !dac_blank_n)
    else $error("blank dropped during flyback");
  chk_par_lock: assert property (@(posedge sys_clk) disable iff (rst)
    (en && reg_wr && reg_addr == VFS_ADR_LINETIME) |=> $stable(linetime_q))
    else $error("parameter changed while running");
endmodule : vfs_frame_gen
`default_nettype wire

// ---- common/vfs_pkg.sv ----
// Package: constants, offsets and types for the video frame sync timing generator
package vfs_pkg;

  // ----------------------------------------------------------------
  // Register map (word indices on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [4:0] VFS_ADR_CTRL = 5'h00;
  localparam logic [4:0] VFS_ADR_BOOT = 5'h01;
  localparam logic [4:0] VFS_ADR_HALFSYNC = 5'h02;
  localparam logic [4:0] VFS_ADR_BACKPORCH = 5'h03;
  localparam logic [4:0] VFS_ADR_DISPLAY = 5'h04;
  localparam logic [4:0] VFS_ADR_SHORTDISP = 5'h05;
  localparam logic [4:0] VFS_ADR_BROADPULSE = 5'h06;
  localparam logic [4:0] VFS_ADR_LINETIME = 5'h07;
  localparam logic [4:0] VFS_ADR_VVISIBLE = 5'h08;
  localparam logic [4:0] VFS_ADR_LEADEQ = 5'h09;
  localparam logic [4:0] VFS_ADR_TRAILEQ = 5'h0a;
  localparam logic [4:0] VFS_ADR_VSYNC = 5'h0b;
  localparam logic [4:0] VFS_ADR_EXTRA_VERTICAL_BLANK_HALFLINES = 5'h0c;
  localparam logic [4:0] VFS_ADR_LEAD = 5'h0d;
  localparam logic [4:0] VFS_ADR_STATUS = 5'h0e;

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int VFS_CTL_EN = 0;
  localparam int VFS_CTL_INTERLACE = 1;
  localparam int VFS_CTL_SLAVE = 2;
  localparam int VFS_CTL_PINSEL_LO = 4;
  localparam int VFS_CTL_NOSYNC = 6;
  localparam int VFS_CTL_DLY_LO = 8;
  localparam int VFS_CTL_NOBLANK = 11;
  localparam logic [11:0] VFS_CTL_RESET = 12'h000;

  // Bootstrap word fields
  localparam int VFS_BOOT_PLL_LO = 0;
  localparam int VFS_BOOT_SRC = 5;
  localparam int VFS_BOOT_ALIGN = 6;
  localparam logic [6:0] VFS_BOOT_RESET = 7'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int VFS_CLK_MHZ = 125;
  localparam int VFS_BOOT_WAIT_NS = 50;
  localparam int VFS_BOOT_WAIT_CYC = (VFS_BOOT_WAIT_NS * VFS_CLK_MHZ + 999) / 1000;
  localparam int VFS_SU_PIXELS = 4;

  // Frame phase
  typedef enum logic [2:0] {
    VFS_PH_IDLE = 3'b000,
    VFS_PH_PREEQ = 3'b001,
    VFS_PH_VSYNC = 3'b011,
    VFS_PH_POSTEQ = 3'b010,
    VFS_PH_EXTRA_VERTICAL_BLANK_HALFLINES = 3'b110,
    VFS_PH_VISIBLE = 3'b111
  } vfs_phase_t;

  // Segment inside a line
  typedef enum logic [2:0] {
    VFS_SG_SYNC1 = 3'b000,
    VFS_SG_SYNC2 = 3'b001,
    VFS_SG_BACK = 3'b011,
    VFS_SG_DISP = 3'b010,
    VFS_SG_FRONT = 3'b110
  } vfs_seg_t;

endpackage : vfs_pkg

// ---- design/vfs_delay_line.sv ----
// Programmable 0..7 cycle delay for sync and blank
`timescale 1ns/1ns
`default_nettype none
module vfs_delay_line #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Data
  input wire logic [2:0] dly_sel,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  wire [WIDTH-1:0] tap [DEPTH];

  // Tap 0 is the undelayed input
  assign tap[0] = din;

  genvar g;
  generate
    for (g = 1; g < DEPTH; g++) begin : g_tap
      // One register per stage, so every tap has a single driver
      logic [WIDTH-1:0] stage_q;
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          stage_q <= '1;
        end else begin
          stage_q <= tap[g-1];
        end
      end
      assign tap[g] = stage_q;
    end
  endgenerate

  assign dout = tap[dly_sel];
endmodule : vfs_delay_line
`default_nettype wire

// ---- dv/vfs_sync_partner.sv ----
// Far-side sync source for slave tests, plus resolution of the sync pin wires
`timescale 1ns/1ns
`default_nettype none
module vfs_sync_partner #(
  parameter int LT = 80,
  parameter int PW = 8
) (
  // Clock
  input wire logic sys_clk,
  // Bench command: start one frame pulse
  input wire logic go,
  // Device pin triples
  input wire logic fs_o,
  input wire logic fs_oe,
  input wire logic cs_o,
  input wire logic cs_oe,
  output logic fs_i,
  output logic cs_i
);
  // ----------------------------------------------------------------
  // Sync source
  // ----------------------------------------------------------------
  int lcnt = 0;
  int fcnt = 0;
  always @(posedge sys_clk) begin
    lcnt <= (lcnt == LT - 1) ? 0 : lcnt + 1;
    fcnt <= go ? LT : (fcnt > 0 ? fcnt - 1 : 0);
  end
  // ----------------------------------------------------------------
  // Wires: pulled up, device wins while its enable is high
  // ----------------------------------------------------------------
  assign fs_i = fs_oe ? fs_o : (fcnt == 0);
  assign cs_i = cs_oe ? cs_o : (lcnt >= PW);
endmodule : vfs_sync_partner
`default_nettype wire

// ---- dv/test_video_frame_sync_timing_generator.sv ----
// Self-checking testbench for the frame sync timing generator
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); end end
module test_video_frame_sync_timing_generator;
  import vfs_pkg::*;
  localparam int HS = 4, BP = 18, LT = 80, BR = 34, VS = 3, PE = 3, QE = 3, VB = 4;
  typedef struct {logic [4:0] a; logic [31:0] d;} vfs_row_t;
  // Legal set: half line 40 sits between 26 and 66, short display below 14
  vfs_row_t rows [12] = '{'{VFS_ADR_HALFSYNC, 32'h4}, '{VFS_ADR_BACKPORCH, 32'h12},
    '{VFS_ADR_DISPLAY, 32'h28}, '{VFS_ADR_SHORTDISP, 32'ha}, '{VFS_ADR_BROADPULSE, 32'h22},
    '{VFS_ADR_LINETIME, 32'h50}, '{VFS_ADR_VVISIBLE, 32'h8}, '{VFS_ADR_LEADEQ, 32'h3},
    '{VFS_ADR_TRAILEQ, 32'h3}, '{VFS_ADR_VSYNC, 32'h3}, '{VFS_ADR_EXTRA_VERTICAL_BLANK_HALFLINES, 32'h4},
    '{VFS_ADR_LEAD, 32'h6}};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic go = 1'b0;
  logic [31:0] reg_rdata;
  logic [4:0] pll_factor;
  logic clk_src_sel, port_align64, fs_i, fs_o, fs_oe, cs_i, cs_o, cs_oe;
  logic dac_sync_n, dac_blank_n, flag;
  logic [31:0] v;
  int n_errors = 0;
  int n_checks = 0;
  int n;
  always #4 sys_clk = ~sys_clk;
  vfs_frame_gen u_vfs_frame_gen (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pll_factor(pll_factor), .clk_src_sel(clk_src_sel), .port_align64(port_align64),
    .frame_sync_pin_n_i(fs_i), .frame_sync_pin_n_o(fs_o), .frame_sync_pin_n_oe(fs_oe),
    .combined_sync_pin_n_i(cs_i), .combined_sync_pin_n_o(cs_o),
    .combined_sync_pin_n_oe(cs_oe), .dac_sync_n(dac_sync_n), .dac_blank_n(dac_blank_n),
    .vertical_flyback_flag(flag));
  vfs_sync_partner #(.LT(LT), .PW(2 * HS)) u_vfs_sync_partner (.sys_clk(sys_clk), .go(go),
    .fs_o(fs_o), .fs_oe(fs_oe), .cs_o(cs_o), .cs_oe(cs_oe), .fs_i(fs_i), .cs_i(cs_i));
  // ----------------------------------------------------------------
  // Bus and wait helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  function automatic logic cur(input int s);
    case (s)
      0: return fs_o;
      1: return cs_o;
      2: return dac_sync_n;
      3: return flag;
      default: return dac_blank_n;
    endcase
  endfunction : cur
  // Counts edges until the watched signal shows the wanted level
  task automatic wait_lvl(input int s, input logic l, input int lim, output int k);
    k = 0;
    while (cur(s) !== l) begin
      @(posedge sys_clk);
      #1 k++;
      if (k > lim) begin
        n_errors++;
        $display("ERROR t=%0t wait ran out", $time);
        give_verdict();
      end
    end
  endtask : wait_lvl
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 `CHK({flag, dac_blank_n, fs_o, fs_oe, cs_o, cs_oe}, 6'b001111)
    wr(VFS_ADR_BOOT, 32'h7f);
    @(posedge sys_clk);
    #1 `CHK(pll_factor, 5'h00)
    repeat (VFS_BOOT_WAIT_CYC) @(posedge sys_clk);
    wr(VFS_ADR_BOOT, 32'h35);
    wr(VFS_ADR_BOOT, 32'h4a);
    @(posedge sys_clk);
    #1 `CHK({port_align64, clk_src_sel, pll_factor}, 7'h35)
    wr(VFS_ADR_CTRL, 32'h0);
    $display("test reset and bootstrap done");
    foreach (rows[i]) wr(rows[i].a, rows[i].d);
    foreach (rows[i]) begin
      rd(rows[i].a, v);
      `CHK(v, rows[i].d)
    end
    rd(5'h1f, v);
    `CHK(v, 32'h0)
    $display("test register rows done");
    wr(VFS_ADR_CTRL, 32'h1);
    wait_lvl(1, 1'b0, 20, n);
    wait_lvl(1, 1'b1, 500, n);
    `CHK(n, HS)
    `CHK(flag, 1'b1)
    wait_lvl(0, 1'b0, 500, n);
    wait_lvl(1, 1'b1, 500, n);
    `CHK(n, BR)
    wait_lvl(0, 1'b1, 500, n);
    wait_lvl(0, 1'b0, 2000, n);
    wait_lvl(0, 1'b1, 500, n);
    `CHK(n, VS * LT / 2)
    wait_lvl(3, 1'b0, 2000, n);
    wait_lvl(4, 1'b1, LT, n);
    wait_lvl(3, 1'b1, 2000, n);
    repeat (LT) @(posedge sys_clk);
    #1 `CHK(dac_blank_n, 1'b0)
    wait_lvl(3, 1'b0, 2000, n);
    wait_lvl(3, 1'b1, 2000, n);
    wait_lvl(3, 1'b0, 2000, n);
    `CHK(n, (PE + VS + QE + VB) * LT / 2)
    wr(VFS_ADR_HALFSYNC, 32'h9);
    rd(VFS_ADR_HALFSYNC, v);
    `CHK(v, 32'h0)
    $display("test frame shape done");
    for (int m = 1; m < 3; m++) begin
      wr(VFS_ADR_CTRL, 32'h0);
      wr(VFS_ADR_CTRL, 32'h1 | (m << VFS_CTL_PINSEL_LO));
      wait_lvl(0, 1'b0, 500, n);
      wait_lvl(1, 1'b1, 500, n);
      `CHK(n, (m == 1) ? VS * LT / 2 : 0)
      wait_lvl(1, 1'b0, 2000, n);
      wait_lvl(1, 1'b1, 20, n);
      `CHK(n, 2 * HS)
    end
    wr(VFS_ADR_CTRL, 32'h0);
    rd(VFS_ADR_HALFSYNC, v);
    `CHK(v, 32'h4)
    wr(VFS_ADR_CTRL, 32'h2);
    wr(VFS_ADR_VVISIBLE, 32'h5);
    rd(VFS_ADR_VVISIBLE, v);
    `CHK(v, 32'h5)
    wr(VFS_ADR_CTRL, 32'h501);
    wait_lvl(1, 1'b0, 20, n);
    wait_lvl(2, 1'b0, 20, n);
    `CHK(n, 5)
    wr(VFS_ADR_CTRL, 32'h0);
    wr(VFS_ADR_CTRL, 32'h841);
    repeat (10) @(posedge sys_clk);
    n = 0;
    repeat (2000) begin
      @(posedge sys_clk);
      #1 n += (dac_sync_n === 1'b1 && dac_blank_n === 1'b1) ? 0 : 1;
    end
    `CHK(n, 0)
    // Stop in the visible area, so the flag is low before the slave start
    wait_lvl(3, 1'b1, 2000, n);
    wait_lvl(3, 1'b0, 2000, n);
    $display("test pin modes and dac feed done");
    wr(VFS_ADR_CTRL, 32'h0);
    wr(VFS_ADR_CTRL, 32'h5);
    repeat (50) @(posedge sys_clk);
    #1 `CHK({fs_oe, cs_oe, flag}, 3'b000)
    @(posedge sys_clk);
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    wait_lvl(3, 1'b1, 12, n);
    rd(VFS_ADR_STATUS, v);
    `CHK(v[7:6], 2'b11)
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 `CHK({flag, dac_blank_n, pll_factor}, 7'h00)
    // A new PLL factor takes the full start-up again
    @(posedge sys_clk);
    rst <= 1'b0;
    repeat (VFS_BOOT_WAIT_CYC) @(posedge sys_clk);
    wr(VFS_ADR_BOOT, 32'h1a);
    @(posedge sys_clk);
    #1 `CHK({port_align64, clk_src_sel, pll_factor}, 7'h1a)
    $display("test slave start and reset done");
    give_verdict();
  end
endmodule : test_video_frame_sync_timing_generator
`default_nettype wire
